// file: include/fifo_status_flags_consts.svh
// Constants of the FIFO status-flag block: offsets, reset values, timing.
// Assumes a 200 MHz core clock shared by writer and reader.
`ifndef FIFO_STATUS_FLAGS_CONSTS_SVH
`define FIFO_STATUS_FLAGS_CONSTS_SVH

// Register port byte addresses
`define FSF_ADDR_EMPTY_OFS 8'h00
`define FSF_ADDR_FULL_OFS 8'h04
`define FSF_ADDR_STATUS 8'h08

// Default offsets picked by the load-select level at master reset
`define FSF_DEF_OFS_LOW 14'h007F
`define FSF_DEF_OFS_HIGH 14'h03FF

// Status register field positions
`define FSF_ST_FULL_N 0
`define FSF_ST_EMPTY_N 1
`define FSF_ST_AFULL_N 2
`define FSF_ST_AEMPTY_N 3
`define FSF_ST_HALF_N 4
`define FSF_ST_FALL_THROUGH_MODE 5
`define FSF_ST_SERIAL 6
`define FSF_ST_SETUP 7
`define FSF_ST_OCC_LSB 16

// Fixed latency of first word and retransmit, in ns and clock cycles
`define FSF_FWL_NS 60
`define FSF_CLK_PS 5000
`define FSF_FWL_CYC ((`FSF_FWL_NS * 1000 + `FSF_CLK_PS - 1) / `FSF_CLK_PS)

`endif

// file: include/fifo_status_flags_pkg.sv
// Types used inside the FIFO status-flag block.
// Constants live in fifo_status_flags_consts.svh.
package fifo_status_flags_pkg;

  // Read-side latency tracker
  typedef enum logic [1:0] {
    LAT_IDLE,
    LAT_FIRST,
    LAT_RETX
  } lat_state_t;

  // Flag bundle, all active low
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic almost_full_n;
    logic almost_empty_n;
    logic half_full_n;
  } flags_t;

endpackage

// file: hw/fifo_status_flags.sv
// FIFO with status flags, offsets, fixed latency and retransmit.
// Assumes writer and reader share i_clk; all inputs synchronous to it.
`timescale 1ns/1ps
`include "fifo_status_flags_consts.svh"

// Contract
// - Standard mode: almost-full low after depth minus full offset writes.
// - Fall-through: almost-full low after depth plus one minus full offset writes.
// - Almost-full changes only on write-side clock edges.
// - Standard mode: almost-empty low while count is at most empty offset.
// - Fall-through: almost-empty low while count incl. output word is at most offset+1.
// - Almost-empty updates on read-side clock edges.
// - Half-full goes low on the write that passes half depth, half depth plus one in fall-through.
// - Half-full returns high on the read edge bringing count to half depth or less, half depth plus one in fall-through.
// - Standard mode: half-full low after half depth plus one writes.
// - Fall-through: half-full low after half depth plus two writes.
// - Read words leave on an 18-bit parallel output.
// - Full deassertion may lag one extra write cycle; tolerated.
// - Empty deassertion may lag one extra read cycle.
// - Standard retransmit: empty flag high 60 ns plus one read cycle later.
// - Fall-through retransmit: output-ready low 60 ns plus two read cycles later.
// - Serial offset fields have top bit 9 to 13 by depth.
// - Almost-full deassertion may slip one extra write cycle.
// - Almost-empty deassertion may slip one extra read cycle.
// - Fall-through input-ready assertion may slip one extra write cycle.
// - Load-select at master reset picks defaults 127 or 1023 and load method.
// - Serial enable and load-select low shift one bit per write edge.
module fifo_status_flags #(
  parameter int DEPTH = 8192,
  parameter int WIDTH = 18
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Reset and mode pins
  input wire logic i_master_reset_n,
  input wire logic i_partial_reset_n,
  input wire logic i_fall_through_mode,
  input wire logic i_offset_load_select_n,
  input wire logic i_serial_load_enable_n,
  input wire logic i_serial_in,
  // Write side
  input wire logic i_wr_en_n,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read side
  input wire logic i_rd_en_n,
  input wire logic i_retransmit_n,
  output logic [WIDTH-1:0] o_read_data_out,
  // Flags, active low
  output logic o_full_flag_n,
  output logic o_input_ready_n,
  output logic o_empty_flag_n,
  output logic o_output_ready_n,
  output logic o_almost_full_flag_n,
  output logic o_almost_empty_flag_n,
  output logic o_half_full_flag_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata
);

  localparam int OFS_W = $clog2(DEPTH);
  localparam int CNT_W = OFS_W + 1;
  localparam int LAT = `FSF_FWL_CYC;

  // Power-of-two depths up to the larger part; below 1024 the 1023 default would not fit
  if (DEPTH < 1024 || DEPTH > 16384 || (DEPTH & (DEPTH - 1)) != 0
      || WIDTH != 18) begin
    $error("fifo_status_flags: unsupported DEPTH or WIDTH");
  end

  // Occupancy between a fill pointer and a drain pointer
  function automatic logic [CNT_W-1:0] occ(input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b);
    occ = a - b;
  endfunction

  // Storage and pointers
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [CNT_W-1:0] wr_ptr_ff;
  logic [CNT_W-1:0] rd_ptr_ff;
  logic [CNT_W-1:0] wr_vis_ff;
  logic [CNT_W-1:0] rd_vis_ff;
  logic out_valid_ff;
  logic [WIDTH-1:0] rdata_ff;

  // Mode and offsets
  logic fall_through_mode_ff;
  logic serial_ff;
  logic [OFS_W-1:0] empty_ofs_ff;
  logic [OFS_W-1:0] full_ofs_ff;

  // Latency tracker
  fifo_status_flags_pkg::lat_state_t lat_state_ff;
  logic [7:0] lat_cnt_ff;

  // Flags
  fifo_status_flags_pkg::flags_t flags_ff;
  logic [31:0] rdata_reg_ff;

  // Derived terms
  logic any_rst;
  logic [CNT_W-1:0] cons;
  logic [CNT_W-1:0] occ_w;
  logic [CNT_W-1:0] occ_r;
  logic [CNT_W-1:0] cap;
  logic [CNT_W-1:0] half_thr;
  logic full;
  logic wr_go;
  logic mem_avail;
  logic setup_busy;
  logic std_rd;
  logic fall_through_mode_load;
  logic fall_through_mode_pop;
  logic retx;
  logic rd_take;

  assign any_rst = !i_master_reset_n || !i_partial_reset_n;
  // Output-register word is part of the count in fall-through mode
  assign cons = rd_ptr_ff - CNT_W'(out_valid_ff);
  assign occ_w = occ(wr_ptr_ff, rd_vis_ff);
  assign occ_r = occ(wr_vis_ff, cons);
  // Capacity D, or D plus the output register
  assign cap = CNT_W'(DEPTH) + CNT_W'(fall_through_mode_ff);
  assign half_thr = CNT_W'(DEPTH / 2) + CNT_W'(fall_through_mode_ff);
  assign full = occ_w >= cap;
  assign wr_go = !i_wr_en_n && !full;
  assign retx = !i_retransmit_n;
  assign setup_busy = lat_state_ff == fifo_status_flags_pkg::LAT_RETX;
  // Read side only sees words released by the latency tracker
  assign mem_avail = (wr_vis_ff != rd_ptr_ff) && !setup_busy;
  assign std_rd = !fall_through_mode_ff && !i_rd_en_n && mem_avail && !retx;
  assign fall_through_mode_pop = fall_through_mode_ff && !i_rd_en_n && out_valid_ff && !retx;
  assign fall_through_mode_load = fall_through_mode_ff && mem_avail && !retx && (!out_valid_ff || fall_through_mode_pop);
  // Any edge that removes one word from the reader's count
  assign rd_take = std_rd || fall_through_mode_pop;

  // Mode capture and offset registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_through_mode_ff <= 1'b0;
      serial_ff <= 1'b0;
      empty_ofs_ff <= OFS_W'(`FSF_DEF_OFS_LOW);
      full_ofs_ff <= OFS_W'(`FSF_DEF_OFS_LOW);
    end else if (i_ce) begin
      if (!i_master_reset_n) begin
        fall_through_mode_ff <= i_fall_through_mode;
        serial_ff <= i_offset_load_select_n;
        if (i_offset_load_select_n) begin
          empty_ofs_ff <= OFS_W'(`FSF_DEF_OFS_HIGH);
          full_ofs_ff <= OFS_W'(`FSF_DEF_OFS_HIGH);
        end else begin
          empty_ofs_ff <= OFS_W'(`FSF_DEF_OFS_LOW);
          full_ofs_ff <= OFS_W'(`FSF_DEF_OFS_LOW);
        end
      end else if (serial_ff && !i_serial_load_enable_n && !i_offset_load_select_n) begin
        // Empty offset first, LSB first, then full offset; OFS_W bits each
        {full_ofs_ff, empty_ofs_ff} <= {i_serial_in, full_ofs_ff, empty_ofs_ff[OFS_W-1:1]};
      end else if (!serial_ff && i_wr) begin
        // Parallel method: software writes offsets directly
        if (i_addr == `FSF_ADDR_EMPTY_OFS) begin
          empty_ofs_ff <= i_wdata[OFS_W-1:0];
        end
        if (i_addr == `FSF_ADDR_FULL_OFS) begin
          full_ofs_ff <= i_wdata[OFS_W-1:0];
        end
      end
    end
  end

  // Write pointer and storage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_ff <= '0;
    end else if (i_ce) begin
      if (any_rst) begin
        wr_ptr_ff <= '0;
      end else if (wr_go) begin
        wr_ptr_ff <= wr_ptr_ff + CNT_W'(1);
      end
    end
  end

  // Storage has no reset; contents are don't-care until written
  always_ff @(posedge i_clk) begin
    if (i_ce && !any_rst && wr_go) begin
      mem_ff[wr_ptr_ff[OFS_W-1:0]] <= i_wr_data;
    end
  end

  // Drain pointer copy seen by write side, one cycle behind
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_vis_ff <= '0;
    end else if (i_ce) begin
      if (any_rst) begin
        rd_vis_ff <= '0;
      end else begin
        rd_vis_ff <= cons;
      end
    end
  end

  // Latency tracker: holds new words back from an empty read side
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lat_state_ff <= fifo_status_flags_pkg::LAT_IDLE;
      lat_cnt_ff <= 8'h00;
      wr_vis_ff <= '0;
    end else if (i_ce) begin
      if (any_rst) begin
        lat_state_ff <= fifo_status_flags_pkg::LAT_IDLE;
        lat_cnt_ff <= 8'h00;
        wr_vis_ff <= '0;
      end else if (retx) begin
        // Retransmit setup reuses the fixed latency
        lat_state_ff <= fifo_status_flags_pkg::LAT_RETX;
        lat_cnt_ff <= 8'(LAT - 1);
      end else begin
        case (lat_state_ff)
          fifo_status_flags_pkg::LAT_IDLE: begin
            if (wr_vis_ff == rd_ptr_ff && wr_ptr_ff != wr_vis_ff) begin
              lat_state_ff <= fifo_status_flags_pkg::LAT_FIRST;
              lat_cnt_ff <= 8'(LAT - 2);
            end else begin
              wr_vis_ff <= wr_ptr_ff;
            end
          end
          fifo_status_flags_pkg::LAT_FIRST,
          fifo_status_flags_pkg::LAT_RETX: begin
            if (lat_cnt_ff == 8'h00) begin
              lat_state_ff <= fifo_status_flags_pkg::LAT_IDLE;
              wr_vis_ff <= wr_ptr_ff;
            end else begin
              lat_cnt_ff <= lat_cnt_ff - 8'h01;
            end
          end
          default: begin
            lat_state_ff <= fifo_status_flags_pkg::LAT_IDLE;
          end
        endcase
      end
    end
  end

  // Read pointer and output register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_ptr_ff <= '0;
      out_valid_ff <= 1'b0;
    end else if (i_ce) begin
      if (any_rst || retx) begin
        // Retransmit restarts at the first word since reset
        rd_ptr_ff <= '0;
        out_valid_ff <= 1'b0;
      end else if (std_rd || fall_through_mode_load) begin
        rd_ptr_ff <= rd_ptr_ff + CNT_W'(1);
        out_valid_ff <= fall_through_mode_ff;
      end else if (fall_through_mode_pop) begin
        out_valid_ff <= 1'b0;
      end
    end
  end

  // Read data from a register; standard mode holds last word when no read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_ff <= '0;
    end else if (i_ce) begin
      if (!i_master_reset_n) begin
        rdata_ff <= '0;
      end else if (std_rd || fall_through_mode_load) begin
        rdata_ff <= mem_ff[rd_ptr_ff[OFS_W-1:0]];
      end
    end
  end

  // Write-side flags: full and almost-full
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff.full_n <= 1'b1;
      flags_ff.almost_full_n <= 1'b1;
    end else if (i_ce) begin
      if (any_rst) begin
        flags_ff.full_n <= 1'b1;
        flags_ff.almost_full_n <= 1'b1;
      end else begin
        flags_ff.full_n <= !full;
        // Cap minus offset: D-m standard, D+1-m fall-through
        flags_ff.almost_full_n <= occ_w < (cap - CNT_W'(full_ofs_ff));
      end
    end
  end

  // Read-side flags: empty and almost-empty
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff.empty_n <= 1'b0;
      flags_ff.almost_empty_n <= 1'b0;
    end else if (i_ce) begin
      if (any_rst) begin
        flags_ff.empty_n <= 1'b0;
        flags_ff.almost_empty_n <= 1'b0;
      end else begin
        // Standard: memory words; fall-through: output word is ready
        // Fall-through ready lags the output load by one edge, drops at once on the last pop
        flags_ff.empty_n <= fall_through_mode_ff ? (out_valid_ff && (fall_through_mode_load || !fall_through_mode_pop)) : mem_avail;
        flags_ff.almost_empty_n <= occ_r > (CNT_W'(empty_ofs_ff) + CNT_W'(fall_through_mode_ff));
      end
    end
  end

  // Half-full: set by a write, cleared by the read side
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff.half_full_n <= 1'b1;
    end else if (i_ce) begin
      if (any_rst) begin
        flags_ff.half_full_n <= 1'b1;
      end else if (wr_go && (occ_w + CNT_W'(1)) > half_thr) begin
        flags_ff.half_full_n <= 1'b0;
      end else if (rd_take && occ(wr_ptr_ff, cons) <= half_thr + CNT_W'(1)) begin
        // Only a read or a reset may clear; the lagging read-side count would bounce it after a write
        flags_ff.half_full_n <= 1'b1;
      end
    end
  end

  // Register port read, data one cycle after the strobe
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg_ff <= 32'h00000000;
    end else if (i_ce) begin
      rdata_reg_ff <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `FSF_ADDR_EMPTY_OFS: rdata_reg_ff <= 32'(empty_ofs_ff);
          `FSF_ADDR_FULL_OFS: rdata_reg_ff <= 32'(full_ofs_ff);
          `FSF_ADDR_STATUS: begin
            rdata_reg_ff[`FSF_ST_FULL_N] <= flags_ff.full_n;
            rdata_reg_ff[`FSF_ST_EMPTY_N] <= flags_ff.empty_n;
            rdata_reg_ff[`FSF_ST_AFULL_N] <= flags_ff.almost_full_n;
            rdata_reg_ff[`FSF_ST_AEMPTY_N] <= flags_ff.almost_empty_n;
            rdata_reg_ff[`FSF_ST_HALF_N] <= flags_ff.half_full_n;
            rdata_reg_ff[`FSF_ST_FALL_THROUGH_MODE] <= fall_through_mode_ff;
            rdata_reg_ff[`FSF_ST_SERIAL] <= serial_ff;
            rdata_reg_ff[`FSF_ST_SETUP] <= setup_busy;
            rdata_reg_ff[`FSF_ST_OCC_LSB +: CNT_W] <= occ_w;
          end
          default: rdata_reg_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // Dual-purpose pins split; the unused one of each pair sits inactive
  assign o_full_flag_n = fall_through_mode_ff ? 1'b1 : flags_ff.full_n;
  assign o_input_ready_n = fall_through_mode_ff ? !flags_ff.full_n : 1'b1;
  assign o_empty_flag_n = fall_through_mode_ff ? 1'b1 : flags_ff.empty_n;
  assign o_output_ready_n = fall_through_mode_ff ? !flags_ff.empty_n : 1'b1;
  assign o_almost_full_flag_n = flags_ff.almost_full_n;
  assign o_almost_empty_flag_n = flags_ff.almost_empty_n;
  assign o_half_full_flag_n = flags_ff.half_full_n;
  assign o_read_data_out = rdata_ff;
  assign o_rdata = rdata_reg_ff;

endmodule

// file: bench/fifo_status_flags_assertions.sv
// Port checker for the flag block, bound to its top.
// Assumes the clock enable stays high around resets and register reads.
`timescale 1ns/1ps
module fifo_status_flags_chk (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_master_reset_n,
  input wire logic i_partial_reset_n,
  input wire logic i_fall_through_mode,
  // Requests
  input wire logic i_wr_en_n,
  input wire logic i_rd_en_n,
  input wire logic i_retransmit_n,
  input wire logic i_rd,
  // Watched outputs
  input wire logic [17:0] o_read_data_out,
  input wire logic o_full_flag_n,
  input wire logic o_empty_flag_n,
  input wire logic o_output_ready_n,
  input wire logic o_almost_full_flag_n,
  input wire logic o_almost_empty_flag_n,
  input wire logic o_half_full_flag_n,
  input wire logic [31:0] o_rdata
);
  logic fall_through_mode_ff;
  logic [15:0] evh_ff;
  logic [3:0] wrh_ff;
  logic [4:0] rdh_ff;

  // Mode as taken during master reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fall_through_mode_ff <= 1'b0;
    end else if (!i_master_reset_n) begin
      fall_through_mode_ff <= i_fall_through_mode;
    end
  end

  // Request ages, so each flag move traces back to a cause
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evh_ff <= 16'h0000;
      wrh_ff <= 4'h0;
      rdh_ff <= 5'h00;
    end else begin
      evh_ff <= {evh_ff[14:0], !i_wr_en_n || !i_retransmit_n};
      wrh_ff <= {wrh_ff[2:0], !i_wr_en_n};
      rdh_ff <= {rdh_ff[3:0], !i_rd_en_n};
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_reset_flags: assert property (
    !(i_master_reset_n && i_partial_reset_n) |=> o_almost_full_flag_n && o_half_full_flag_n
      && !o_almost_empty_flag_n) else $error("flags off after reset");
  a_half_fall: assert property ($fell(o_half_full_flag_n) |-> wrh_ff != 4'h0)
    else $error("half-full fell without write");
  a_afull_fall: assert property ($fell(o_almost_full_flag_n) |-> wrh_ff != 4'h0)
    else $error("almost-full fell without write");
  a_half_rise: assert property (
    $rose(o_half_full_flag_n) && $past(i_master_reset_n) && $past(i_partial_reset_n)
      |-> rdh_ff != 5'h00) else $error("half-full rose without read");
  a_std_latency: assert property (
    $rose(o_empty_flag_n) && !fall_through_mode_ff |-> evh_ff[14:11] != 4'h0)
    else $error("empty flag off latency");
  a_fall_through_mode_latency: assert property (
    $fell(o_output_ready_n) && fall_through_mode_ff |-> evh_ff[15:12] != 4'h0)
    else $error("output ready off latency");
  a_data_hold: assert property (
    !fall_through_mode_ff && $past(i_rd_en_n) && $past(i_rd_en_n, 2) && $past(i_retransmit_n)
      && $past(i_master_reset_n) && $past(i_partial_reset_n) |-> $stable(o_read_data_out))
    else $error("data moved without read");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("register data out of slot");
  a_full_levels: assert property (
    !o_full_flag_n |-> !o_almost_full_flag_n && !o_half_full_flag_n)
    else $error("full without partial flags");
endmodule

bind fifo_status_flags fifo_status_flags_chk u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_master_reset_n(i_master_reset_n),
  .i_partial_reset_n(i_partial_reset_n), .i_fall_through_mode(i_fall_through_mode),
  .i_wr_en_n(i_wr_en_n), .i_rd_en_n(i_rd_en_n), .i_retransmit_n(i_retransmit_n),
  .i_rd(i_rd), .o_read_data_out(o_read_data_out), .o_full_flag_n(o_full_flag_n),
  .o_empty_flag_n(o_empty_flag_n), .o_output_ready_n(o_output_ready_n),
  .o_almost_full_flag_n(o_almost_full_flag_n), .o_almost_empty_flag_n(o_almost_empty_flag_n),
  .o_half_full_flag_n(o_half_full_flag_n), .o_rdata(o_rdata)
);

// file: bench/fifo_peer.sv
// Far-side writer and reader model.
// Assumes calls begin just after a rising edge.
`timescale 1ns/1ps
module fifo_peer (
  // Clock and status
  input wire logic i_clk,
  input wire logic i_empty_flag_n,
  // Write side
  output logic o_wr_en_n,
  output logic [17:0] o_wr_data,
  // Read side
  output logic o_rd_en_n,
  output logic o_retransmit_n
);
  // Idle levels
  initial begin
    o_wr_en_n = 1'b1;
    o_wr_data = 18'h3FFFF;
    o_rd_en_n = 1'b1;
    o_retransmit_n = 1'b1;
  end

  // Data flips once released, so a stale word never matches
  task automatic put(input logic [17:0] d);
    o_wr_en_n <= 1'b0;
    o_wr_data <= d;
    @(posedge i_clk);
    o_wr_en_n <= 1'b1;
    o_wr_data <= ~d;
  endtask

  // Standard mode waits out retransmit setup first
  task automatic take(input bit std);
    int n;
    n = 0;
    while (std && i_empty_flag_n !== 1'b1 && n < 40) begin
      @(posedge i_clk);
      n++;
    end
    o_rd_en_n <= 1'b0;
    @(posedge i_clk);
    o_rd_en_n <= 1'b1;
  endtask

  task automatic retx();
    o_retransmit_n <= 1'b0;
    @(posedge i_clk);
    o_retransmit_n <= 1'b1;
  endtask
endmodule

// file: bench/fifo_status_flags_tb.sv
// Bench: fill, latency and retransmit in both modes, drain in standard mode.
// Assumes the peer drives the data side.
`timescale 1ns/1ps
module fifo_status_flags_tb;
  localparam int D = 1024;
  localparam int N = 4;
  localparam int M = 8;
  logic i_clk, i_rst_n, mrst_n, prst_n, fall_through_mode, ld_n, wr, rd, ce, sen_n, si;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic wr_en_n, rd_en_n, retx_n, full_n, ir_n, ef_n, or_n, af_n, ae_n, hf_n;
  logic [17:0] wr_data, q;
  int err_total = 0;
  int total_checks = 0;

  fifo_status_flags #(.DEPTH(D), .WIDTH(18)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_ce(ce), .i_master_reset_n(mrst_n),
    .i_partial_reset_n(prst_n), .i_fall_through_mode(fall_through_mode), .i_offset_load_select_n(ld_n),
    .i_serial_load_enable_n(sen_n), .i_serial_in(si), .i_wr_en_n(wr_en_n),
    .i_wr_data(wr_data), .i_rd_en_n(rd_en_n), .i_retransmit_n(retx_n), .o_read_data_out(q),
    .o_full_flag_n(full_n), .o_input_ready_n(ir_n), .o_empty_flag_n(ef_n),
    .o_output_ready_n(or_n), .o_almost_full_flag_n(af_n), .o_almost_empty_flag_n(ae_n),
    .o_half_full_flag_n(hf_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata));

  fifo_peer u_peer (.i_clk(i_clk), .i_empty_flag_n(ef_n), .o_wr_en_n(wr_en_n),
    .o_wr_data(wr_data), .o_rd_en_n(rd_en_n), .o_retransmit_n(retx_n));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Watchdog well past the expected run of some 21000 cycles
  initial begin
    repeat (40000) @(posedge i_clk);
    err_total++;
    stop_test();
  end

  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    @(posedge i_clk);
  endtask

  // Answer stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, "register");
    @(posedge i_clk);
  endtask

  task automatic mreset(input logic ft);
    fall_through_mode <= ft;
    ld_n <= 1'b0;
    mrst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    mrst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(32'({af_n, hf_n, ae_n, ef_n}), ft ? 32'hD : 32'hC, "master reset");
    @(posedge i_clk);
    reg_rd(8'h00, 32'h7F);
    reg_wr(8'h00, N);
    reg_wr(8'h04, M);
    reg_rd(8'h04, M);
    reg_rd(8'h0C, 32'h0);
  endtask

  task automatic preset();
    prst_n <= 1'b0;
    @(posedge i_clk);
    prst_n <= 1'b1;
    @(posedge i_clk);
    #1;
    chk(32'({af_n, hf_n, ae_n}), 32'h6, "partial reset");
    @(posedge i_clk);
  endtask

  // Counts edges until the data-ready flag shows, skipping early lag
  task automatic lat(input bit use_or, input int lo);
    int c;
    c = 0;
    do begin
      @(posedge i_clk);
      #1;
      c++;
    end while ((c < 2 || (use_or ? or_n !== 1'b0 : ef_n !== 1'b1)) && c < 40);
    chk(32'(c == lo || c == lo + 1), 1, "latency");
    @(posedge i_clk);
  endtask

  task automatic t_fill(input bit ft);
    int dd, k;
    dd = ft ? D + 1 : D;
    for (k = 1; k <= dd; k++) begin
      u_peer.put(18'(k));
      // Words into an empty read side wait out the release latency
      repeat ((k <= 2) ? 15 : 4) @(posedge i_clk);
      #1;
      chk(32'({af_n, hf_n, ae_n}), 32'({k < dd - M, k < D / 2 + 1 + ft, k > N + ft}),
        "fill flags");
      @(posedge i_clk);
    end
    chk(32'({full_n, ir_n}), ft ? 32'h3 : 32'h1, "full");
  endtask

  task automatic t_drain();
    int k;
    for (k = 1; k <= D; k++) begin
      u_peer.take(1'b1);
      repeat (6) @(posedge i_clk);
      #1;
      chk(32'(q), k, "drain data");
      chk(32'({af_n, hf_n, ae_n}), 32'({D - k < D - M, D - k <= D / 2, D - k > N}),
        "drain flags");
      @(posedge i_clk);
    end
  endtask

  // Three words stay well under D minus two before setup
  task automatic t_retx(input bit ft);
    int k;
    for (k = 1; k <= 3; k++) begin
      u_peer.put(18'(k + 8));
      @(posedge i_clk);
    end
    repeat (16) @(posedge i_clk);
    u_peer.take(!ft);
    u_peer.retx();
    lat(ft, ft ? 14 : 13);
    if (!ft) u_peer.take(1'b1);
    repeat (2) @(posedge i_clk);
    #1;
    chk(32'(q), 9, "retransmit word");
    @(posedge i_clk);
  endtask

  // A write offered while the enable is low must be lost
  task automatic t_freeze();
    ce <= 1'b0;
    u_peer.put(18'h00123);
    ce <= 1'b1;
    repeat (15) @(posedge i_clk);
    #1;
    chk(32'({ef_n, ae_n}), 32'h0, "frozen write");
    @(posedge i_clk);
  endtask

  // Serial method: defaults 1023, parallel writes refused, two 10-bit fields shifted
  task automatic t_serial();
    int k;
    logic [19:0] v;
    v = {10'h009, 10'h006};
    fall_through_mode <= 1'b0;
    ld_n <= 1'b1;
    mrst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    mrst_n <= 1'b1;
    @(posedge i_clk);
    reg_wr(8'h00, 32'h5);
    reg_rd(8'h00, 32'h3FF);
    reg_rd(8'h08, 32'h55);
    sen_n <= 1'b0;
    ld_n <= 1'b0;
    for (k = 0; k < 20; k++) begin
      si <= v[k];
      @(posedge i_clk);
    end
    sen_n <= 1'b1;
    ld_n <= 1'b1;
    reg_rd(8'h00, 32'h6);
    reg_rd(8'h04, 32'h9);
  endtask

  // Main sequence
  initial begin
    {i_rst_n, fall_through_mode, ld_n, wr, rd} = 5'h00;
    {mrst_n, prst_n} = 2'h3;
    {ce, sen_n, si} = 3'h6;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    mreset(1'b0);
    u_peer.put(18'h2A5A5);
    lat(1'b0, 13);
    preset();
    t_fill(1'b0);
    reg_rd(8'h08, 32'h0400000A);
    t_drain();
    chk(32'(ef_n), 0, "empty after drain");
    t_freeze();
    preset();
    t_retx(1'b0);
    mreset(1'b1);
    u_peer.put(18'h15A5A);
    lat(1'b1, 14);
    #1;
    chk(32'(q), 32'h15A5A, "first word");
    @(posedge i_clk);
    preset();
    t_fill(1'b1);
    preset();
    t_retx(1'b1);
    t_serial();
    stop_test();
  end
endmodule
